// *** hdl/tlic_irq_ctrl.sv ***
// two-level interrupt controller: gating, arbitration, vectoring, nesting
// assumes the core flags instruction boundaries, owns the stack memory and
// reports a return-from-interrupt as a one-cycle pulse
//
// Summary of operation
// - global enable bit clear blocks every source; set passes enabled ones
// - primary enable: adc bit 6, timer 2 bit 5, uart bit 4
// - primary enable: timer 1 bit 3, ext 1 bit 2, timer 0 bit 1, ext 0 bit 0
// - priority register bits 6..0 choose high level per source; bit 7 reserved
// - secondary register priority: interval bit 6, supply bit 5, serial bit 4
// - secondary register enable: interval bit 2, supply bit 1, serial bit 0
// - high-level request preempts a running low-level service routine
// - simultaneous requests of both levels: high level is vectored first
// - no request preempts a routine of its own level
// - same-level ties resolve by the fixed polling order
// - accepted request pushes the program counter, then loads the vector
// - each source jumps to its own fixed vector address
// - primary enable and priority registers power up cleared
// - secondary register powers up with bits 7 and 5 set
`timescale 1ns/1ps
module tlic_irq_ctrl
    import tlic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // special-register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // peripheral request flags
    input wire logic supply_mon_flag,
    input wire logic watchdog_irq_flag,
    input wire logic ext0_request_flag,
    input wire logic adc_done_flag,
    input wire logic tmr0_overflow_flag,
    input wire logic ext1_request_flag,
    input wire logic tmr1_overflow_flag,
    input wire logic serial_spi_i2c_flag,
    input wire logic uart_rx_done_flag,
    input wire logic uart_tx_done_flag,
    input wire logic tmr2_overflow_flag,
    input wire logic tmr2_external_flag,
    input wire logic interval_cnt_flag,
    // core fetch side
    input wire logic core_boundary,
    input wire logic [15:0] core_pc,
    input wire logic core_reti,
    // stack and program counter control
    output logic irq_push,
    output logic [15:0] irq_push_pc,
    output logic irq_load,
    output logic [15:0] irq_vector,
    output logic irq_pop,
    // nesting status
    output logic in_service_hi,
    output logic in_service_lo
);
    import tlic_pkg::*;

    logic [7:0] ie_q;
    logic [7:0] ip_q;
    logic [7:0] irq_enable_prio_secondary_q;
    logic global_irq_enable;
    logic [TLIC_NSRC-1:0] flags;
    logic [TLIC_NSRC-1:0] src_en;
    logic [TLIC_NSRC-1:0] src_prio;
    logic [TLIC_NSRC-1:0] elig;
    logic [TLIC_NSRC-1:0] hi_req;
    logic [TLIC_NSRC-1:0] lo_req;
    logic hi_valid;
    logic lo_valid;
    logic [3:0] hi_idx;
    logic [3:0] lo_idx;
    logic hi_ok;
    logic lo_ok;
    logic accept;
    tlic_ctl_t c_q, c_d;

    tlic_sfr_regs u_regs (
        .sys_clk(sys_clk),
        .rst(rst),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .ie_q(ie_q),
        .ip_q(ip_q),
        .irq_enable_prio_secondary_q(irq_enable_prio_secondary_q)
    );

    assign global_irq_enable = ie_q[TLIC_B_GLOBAL];

    // request flags in polling order; shared sources are ored
    always_comb begin
        flags = '0;
        flags[TLIC_S_SM] = supply_mon_flag;
        flags[TLIC_S_WD] = watchdog_irq_flag;
        flags[TLIC_S_EXT0] = ext0_request_flag;
        flags[TLIC_S_ADC] = adc_done_flag;
        flags[TLIC_S_TMR0] = tmr0_overflow_flag;
        flags[TLIC_S_EXT1] = ext1_request_flag;
        flags[TLIC_S_TMR1] = tmr1_overflow_flag;
        flags[TLIC_S_SER] = serial_spi_i2c_flag;
        flags[TLIC_S_UART] = uart_rx_done_flag | uart_tx_done_flag;
        flags[TLIC_S_TMR2] = tmr2_overflow_flag | tmr2_external_flag;
        flags[TLIC_S_IC] = interval_cnt_flag;
    end

    // per-source enables; the watchdog has no enable bit, only the global enable gates it
    always_comb begin
        src_en = '0;
        src_en[TLIC_S_ADC] = ie_q[TLIC_B_ADC];
        src_en[TLIC_S_TMR2] = ie_q[TLIC_B_TMR2];
        src_en[TLIC_S_UART] = ie_q[TLIC_B_UART];
        src_en[TLIC_S_TMR1] = ie_q[TLIC_B_TMR1];
        src_en[TLIC_S_EXT1] = ie_q[TLIC_B_EXT1];
        src_en[TLIC_S_TMR0] = ie_q[TLIC_B_TMR0];
        src_en[TLIC_S_EXT0] = ie_q[TLIC_B_EXT0];
        src_en[TLIC_S_IC] = irq_enable_prio_secondary_q[TLIC_B_IC_EN];
        src_en[TLIC_S_SM] = irq_enable_prio_secondary_q[TLIC_B_SM_EN];
        src_en[TLIC_S_SER] = irq_enable_prio_secondary_q[TLIC_B_SER_EN];
        src_en[TLIC_S_WD] = 1'b1;
    end

    // per-source level; the watchdog is fixed at the high level
    always_comb begin
        src_prio = '0;
        src_prio[TLIC_S_ADC] = ip_q[TLIC_B_ADC];
        src_prio[TLIC_S_TMR2] = ip_q[TLIC_B_TMR2];
        src_prio[TLIC_S_UART] = ip_q[TLIC_B_UART];
        src_prio[TLIC_S_TMR1] = ip_q[TLIC_B_TMR1];
        src_prio[TLIC_S_EXT1] = ip_q[TLIC_B_EXT1];
        src_prio[TLIC_S_TMR0] = ip_q[TLIC_B_TMR0];
        src_prio[TLIC_S_EXT0] = ip_q[TLIC_B_EXT0];
        src_prio[TLIC_S_IC] = irq_enable_prio_secondary_q[TLIC_B_IC_PRIO];
        src_prio[TLIC_S_SM] = irq_enable_prio_secondary_q[TLIC_B_SM_PRIO];
        src_prio[TLIC_S_SER] = irq_enable_prio_secondary_q[TLIC_B_SER_PRIO];
        src_prio[TLIC_S_WD] = 1'b1;
    end

    assign elig = flags & src_en & {TLIC_NSRC{global_irq_enable}};
    assign hi_req = elig & src_prio;
    assign lo_req = elig & ~src_prio;

    // one fixed-order pick per level
    tlic_prio_pick #(.N(TLIC_NSRC), .W(4)) u_pick_hi (
        .req(hi_req),
        .valid(hi_valid),
        .idx(hi_idx)
    );

    tlic_prio_pick #(.N(TLIC_NSRC), .W(4)) u_pick_lo (
        .req(lo_req),
        .valid(lo_valid),
        .idx(lo_idx)
    );

    // high may nest over low; nothing nests over its own level
    assign hi_ok = hi_valid && !c_q.ins_hi;
    assign lo_ok = lo_valid && !c_q.ins_hi && !c_q.ins_lo;
    assign accept = (c_q.st == TLIC_IDLE) && core_boundary && (hi_ok || lo_ok);

    always_comb begin
        c_d = c_q;
        case (c_q.st)
            TLIC_IDLE: begin
                if (accept) begin
                    // the high level wins a same-cycle contest
                    c_d.lvl_hi = hi_ok;
                    c_d.idx = hi_ok ? hi_idx : lo_idx;
                    c_d.vec = TLIC_VEC[hi_ok ? hi_idx : lo_idx];
                    c_d.push_pc = core_pc;
                    // mark the level at once so the same level cannot slip in again
                    if (hi_ok) begin
                        c_d.ins_hi = 1'b1;
                    end else begin
                        c_d.ins_lo = 1'b1;
                    end
                    c_d.st = TLIC_PUSH;
                end
            end
            TLIC_PUSH: begin
                c_d.st = TLIC_LOAD;
            end
            TLIC_LOAD: begin
                c_d.st = TLIC_IDLE;
            end
            default: begin
                c_d.st = TLIC_IDLE;
            end
        endcase
        // a return closes the innermost routine, which is the high one if any
        if (core_reti && c_q.st == TLIC_IDLE) begin
            if (c_q.ins_hi) begin
                c_d.ins_hi = 1'b0;
            end else begin
                c_d.ins_lo = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            c_q <= TLIC_CTL_RST;
        end else begin
            c_q <= c_d;
        end
    end

    assign irq_push = (c_q.st == TLIC_PUSH);
    assign irq_load = (c_q.st == TLIC_LOAD);
    assign irq_push_pc = c_q.push_pc;
    assign irq_vector = c_q.vec;
    // returns during a vectoring sequence are not honoured, so no pop then
    assign irq_pop = core_reti && (c_q.st == TLIC_IDLE);
    assign in_service_hi = c_q.ins_hi;
    assign in_service_lo = c_q.ins_lo;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_push;
        irq_push && !irq_load;
    endsequence

    sequence s_load;
        irq_load && !irq_push;
    endsequence

    global_gate_a: assert property (!global_irq_enable |-> !accept)
        else $error("request taken while global enable is clear");

    eligible_only_a: assert property (accept |-> elig[c_d.idx] && flags[c_d.idx] && src_en[c_d.idx])
        else $error("ineligible source taken");

    push_load_a: assert property (accept |=> s_push ##1 s_load ##1 !irq_push && !irq_load)
        else $error("push then load sequence broken");

    push_pc_a: assert property (accept |=> irq_push_pc == $past(core_pc))
        else $error("pushed counter differs from counter at accept");

    vector_map_a: assert property (irq_load |-> irq_vector == TLIC_VEC[c_q.idx])
        else $error("vector does not match source");

    high_first_a: assert property (accept && hi_valid && !c_q.ins_hi |=> c_q.lvl_hi && c_q.ins_hi)
        else $error("low request vectored ahead of high");

    preempt_low_a: assert property (
        c_q.st == TLIC_IDLE && core_boundary && c_q.ins_lo && !c_q.ins_hi && hi_valid |-> accept)
        else $error("high request failed to preempt low routine");

    same_level_a: assert property (c_q.ins_hi |-> !accept)
        else $error("request nested over high routine");

    low_blocked_a: assert property (c_q.ins_lo && accept |=> c_q.lvl_hi)
        else $error("low request nested over low routine");

    poll_order_a: assert property (accept && !hi_ok |=> (lo_req & ((11'h001 << c_q.idx) - 11'h001)) == '0
        || $past(lo_req & ((11'h001 << c_d.idx) - 11'h001)) == '0)
        else $error("polling order not kept");

    reti_clear_a: assert property (core_reti && c_q.st == TLIC_IDLE && c_q.ins_hi |=> !c_q.ins_hi && irq_pop == 1'b0
        || !c_q.ins_hi)
        else $error("return did not clear high in-service mark");

    reti_pop_a: assert property (core_reti && c_q.st == TLIC_IDLE |-> irq_pop)
        else $error("return did not pop");

endmodule : tlic_irq_ctrl

// *** hdl/tlic_pkg.sv ***
// constants and types for the two-level interrupt controller
// assumes a single core clock and the core's special-register port
package tlic_pkg;

    // special-register addresses
    localparam logic [7:0] TLIC_ADDR_IE = 8'ha8;
    localparam logic [7:0] TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY = 8'ha9;
    localparam logic [7:0] TLIC_ADDR_IP = 8'hb8;

    // power-on values
    localparam logic [7:0] TLIC_IE_RST = 8'h00;
    localparam logic [7:0] TLIC_IP_RST = 8'h00;
    localparam logic [7:0] TLIC_IRQ_ENABLE_PRIO_SECONDARY_RST = 8'ha0;

    // primary enable / priority bit positions
    localparam int TLIC_B_GLOBAL = 7;
    localparam int TLIC_B_ADC = 6;
    localparam int TLIC_B_TMR2 = 5;
    localparam int TLIC_B_UART = 4;
    localparam int TLIC_B_TMR1 = 3;
    localparam int TLIC_B_EXT1 = 2;
    localparam int TLIC_B_TMR0 = 1;
    localparam int TLIC_B_EXT0 = 0;

    // secondary register bit positions
    localparam int TLIC_B_IC_PRIO = 6;
    localparam int TLIC_B_SM_PRIO = 5;
    localparam int TLIC_B_SER_PRIO = 4;
    localparam int TLIC_B_MUST_ZERO = 3;
    localparam int TLIC_B_IC_EN = 2;
    localparam int TLIC_B_SM_EN = 1;
    localparam int TLIC_B_SER_EN = 0;
    localparam logic [7:0] TLIC_IP_WMASK = 8'h7f;
    // bit 7 reads as a fixed one and bit 3 as a fixed zero, so neither is writable
    localparam logic [7:0] TLIC_IRQ_ENABLE_PRIO_SECONDARY_WMASK = 8'h77;

    // source index = place in the polling order, 0 polled first
    localparam int TLIC_NSRC = 11;
    localparam int TLIC_S_SM = 0;
    localparam int TLIC_S_WD = 1;
    localparam int TLIC_S_EXT0 = 2;
    localparam int TLIC_S_ADC = 3;
    localparam int TLIC_S_TMR0 = 4;
    localparam int TLIC_S_EXT1 = 5;
    localparam int TLIC_S_TMR1 = 6;
    localparam int TLIC_S_SER = 7;
    localparam int TLIC_S_UART = 8;
    localparam int TLIC_S_TMR2 = 9;
    localparam int TLIC_S_IC = 10;

    // vector per source, same index order
    localparam logic [15:0] TLIC_VEC [0:TLIC_NSRC-1] = '{
        16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
        16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};

    typedef enum logic [2:0] {
        TLIC_IDLE = 3'b001,
        TLIC_PUSH = 3'b010,
        TLIC_LOAD = 3'b100
    } tlic_state_t;

    typedef struct packed {
        tlic_state_t st;
        logic ins_hi;
        logic ins_lo;
        logic lvl_hi;
        logic [3:0] idx;
        logic [15:0] push_pc;
        logic [15:0] vec;
    } tlic_ctl_t;

    localparam tlic_ctl_t TLIC_CTL_RST = '{st: TLIC_IDLE, ins_hi: 1'b0, ins_lo: 1'b0,
        lvl_hi: 1'b0, idx: 4'h0, push_pc: 16'h0000, vec: 16'h0000};

    typedef struct packed {
        logic [7:0] ie;
        logic [7:0] ip;
        logic [7:0] irq_enable_prio_secondary;
        logic [7:0] rdata;
    } tlic_regs_t;

endpackage : tlic_pkg

// *** hdl/tlic_prio_pick.sv ***
// fixed-order pick: lowest set request index wins
// assumes requests are already gated and stable within the cycle
`timescale 1ns/1ps
module tlic_prio_pick #(
    parameter int N = 11,
    parameter int W = 4
) (
    // requests
    input wire logic [N-1:0] req,
    // result
    output logic valid,
    output logic [W-1:0] idx
);
    logic [N:0] seen;
    logic [N-1:0] hit;

    assign seen[0] = 1'b0;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_chain
            assign hit[i] = req[i] & ~seen[i];
            assign seen[i+1] = seen[i] | req[i];
        end
    endgenerate

    always_comb begin
        idx = '0;
        for (int k = 0; k < N; k++) begin
            if (hit[k]) begin
                idx = W'(k);
            end
        end
    end

    assign valid = seen[N];

endmodule : tlic_prio_pick

// *** hdl/tlic_sfr_regs.sv ***
// the three interrupt special registers on the core's register port
// assumes single-cycle byte writes; read data follows the address by one cycle
`timescale 1ns/1ps
module tlic_sfr_regs
    import tlic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // register contents
    output logic [7:0] ie_q,
    output logic [7:0] ip_q,
    output logic [7:0] irq_enable_prio_secondary_q
);
    tlic_regs_t r_q, r_d;

    always_comb begin
        r_d = r_q;
        if (sfr_wr && sfr_addr == TLIC_ADDR_IE) begin
            r_d.ie = sfr_wdata;
        end else if (sfr_wr && sfr_addr == TLIC_ADDR_IP) begin
            r_d.ip = sfr_wdata & TLIC_IP_WMASK;
        end else if (sfr_wr && sfr_addr == TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY) begin
            // bit 3 is held at zero whatever software writes
            r_d.irq_enable_prio_secondary = (sfr_wdata & TLIC_IRQ_ENABLE_PRIO_SECONDARY_WMASK) | (r_q.irq_enable_prio_secondary & ~TLIC_IRQ_ENABLE_PRIO_SECONDARY_WMASK);
        end
        if (sfr_addr == TLIC_ADDR_IE) begin
            r_d.rdata = r_q.ie;
        end else if (sfr_addr == TLIC_ADDR_IP) begin
            r_d.rdata = r_q.ip;
        end else if (sfr_addr == TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY) begin
            r_d.rdata = r_q.irq_enable_prio_secondary;
        end else begin
            r_d.rdata = 8'h00;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r_q <= '{ie: TLIC_IE_RST, ip: TLIC_IP_RST, irq_enable_prio_secondary: TLIC_IRQ_ENABLE_PRIO_SECONDARY_RST, rdata: 8'h00};
        end else begin
            r_q <= r_d;
        end
    end

    assign sfr_rdata = r_q.rdata;
    assign ie_q = r_q.ie;
    assign ip_q = r_q.ip;
    assign irq_enable_prio_secondary_q = r_q.irq_enable_prio_secondary;

    reset_clear_a: assert property (@(posedge sys_clk) rst |-> ie_q == 8'h00 && ip_q == 8'h00)
        else $error("enable or priority not cleared in reset");
    reset_second_a: assert property (@(posedge sys_clk) rst |-> irq_enable_prio_secondary_q == 8'ha0)
        else $error("secondary register not at default in reset");
    zero_bit_a: assert property (@(posedge sys_clk) disable iff (rst) !irq_enable_prio_secondary_q[3])
        else $error("secondary register bit 3 not zero");

endmodule : tlic_sfr_regs

// *** sim/tb.sv ***
// self-checking bench for the two-level interrupt controller
// assumes tlic_pkg and the core model; a reference model predicts each vector
`timescale 1ns/1ps
module tb;
    import tlic_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [10:0] fl = 11'h000;
    logic [1:0] alt = 2'h1;
    logic bnd_en = 1'b0;
    logic slow = 1'b0;
    logic ret_cmd = 1'b0;
    logic [7:0] sfr_rdata;
    logic core_boundary, core_reti, irq_push, irq_load, irq_pop, ins_hi, ins_lo;
    logic [15:0] core_pc, irq_push_pc, irq_vector, pc_smp;
    logic [7:0] ie, ip, ie2;
    logic m_hi, m_lo;
    int n_mismatch = 0;
    int n_tests = 0;
    // enable / priority place per source: 0..7 primary regs, 8..15 secondary, -1 fixed
    int en_loc [11] = '{9, -1, 0, 6, 1, 2, 3, 8, 4, 5, 10};
    int pr_loc [11] = '{13, -1, 0, 6, 1, 2, 3, 12, 4, 5, 14};

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) pc_smp = core_pc;

    tlic_irq_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .supply_mon_flag(fl[0]),
        .watchdog_irq_flag(fl[1]), .ext0_request_flag(fl[2]), .adc_done_flag(fl[3]),
        .tmr0_overflow_flag(fl[4]), .ext1_request_flag(fl[5]), .tmr1_overflow_flag(fl[6]),
        .serial_spi_i2c_flag(fl[7]), .uart_rx_done_flag(fl[8] & alt[0]),
        .uart_tx_done_flag(fl[8] & alt[1]), .tmr2_overflow_flag(fl[9] & alt[0]),
        .tmr2_external_flag(fl[9] & alt[1]), .interval_cnt_flag(fl[10]),
        .core_boundary(core_boundary), .core_pc(core_pc), .core_reti(core_reti),
        .irq_push(irq_push), .irq_push_pc(irq_push_pc), .irq_load(irq_load),
        .irq_vector(irq_vector), .irq_pop(irq_pop), .in_service_hi(ins_hi), .in_service_lo(ins_lo));

    tlic_core_model i_core (.sys_clk(sys_clk), .rst(rst), .bnd_en(bnd_en), .slow(slow),
        .ret_cmd(ret_cmd), .irq_push(irq_push), .irq_push_pc(irq_push_pc), .irq_load(irq_load),
        .irq_vector(irq_vector), .irq_pop(irq_pop), .core_boundary(core_boundary),
        .core_pc(core_pc), .core_reti(core_reti));

    task automatic close_out;
        $display("counts: tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
        if (a == TLIC_ADDR_IE) ie = d;
        if (a == TLIC_ADDR_IP) ip = d & 8'h7f;
        if (a == TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY) ie2 = (d & 8'hf7) | 8'h80;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        tick(2);
        check({8'h00, sfr_rdata}, {8'h00, exp});
    endtask : rd

    task automatic chk_regs;
        rd(TLIC_ADDR_IE, ie);
        rd(TLIC_ADDR_IP, ip);
        rd(TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY, ie2);
        rd(8'h55, 8'h00);
    endtask : chk_regs

    function automatic logic sel(input int loc, input logic [7:0] r);
        if (loc < 0) return 1'b1;
        if (loc > 7) return ie2[loc-8];
        return r[loc];
    endfunction : sel

    // high level polled first, then the fixed order inside the level
    function automatic int pick;
        int w;
        w = -1;
        for (int lv = 1; lv >= 0; lv--)
            for (int i = 0; i < 11; i++)
                if (w < 0 && fl[i] && ie[7] && sel(en_loc[i], ie) && sel(pr_loc[i], ip) == lv
                    && !m_hi && (lv == 1 || !m_lo)) w = i;
        return w;
    endfunction : pick

    task automatic step;
        int w;
        int k;
        w = pick();
        k = 0;
        bnd_en = 1'b1;
        while (irq_push !== 1'b1 && k < 12) begin
            tick(1);
            k++;
        end
        bnd_en = 1'b0;
        if (w < 0) begin
            check({15'h0, irq_push}, 16'h0);
            return;
        end
        if (k == 12) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, irq_push, 1'b1);
            close_out();
        end
        check(irq_vector, TLIC_VEC[w]);
        check(irq_push_pc, pc_smp);
        if (sel(pr_loc[w], ip)) m_hi = 1'b1;
        else m_lo = 1'b1;
        check({14'h0, ins_hi, ins_lo}, {14'h0, m_hi, m_lo});
        tick(1);
        check({14'h0, irq_push, irq_load}, 16'h0001);
        tick(1);
    endtask : step

    task automatic ret;
        ret_cmd = 1'b1;
        #1;
        check({15'h0, irq_pop}, 16'h0001);
        tick(1);
        ret_cmd = 1'b0;
        if (m_hi) m_hi = 1'b0;
        else m_lo = 1'b0;
        check({14'h0, ins_hi, ins_lo}, {14'h0, m_hi, m_lo});
    endtask : ret

    initial begin
        // a real rising edge on rst, so the registers are cleared before the first clock
        rst = 1'b1;
        void'($urandom(67595));
        {ie, ip, ie2, m_hi, m_lo} = {8'h00, 8'h00, 8'ha0, 2'b00};
        tick(2);
        rst = 1'b0;
        chk_regs();
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            wr(TLIC_ADDR_IE, 8'($urandom));
            wr(TLIC_ADDR_IP, 8'($urandom));
            wr(TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY, 8'($urandom) & 8'hf7);
            wr(8'h55, 8'($urandom));
            chk_regs();
        end
        $display("test register_access done");
        wr(TLIC_ADDR_IE, 8'h7f);
        wr(TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY, 8'h07);
        fl = 11'h7ff;
        step();
        $display("test global_gate done");
        wr(TLIC_ADDR_IP, 8'h00);
        for (int i = 0; i < 11; i++) begin
            wr(TLIC_ADDR_IE, 8'h80 | ((en_loc[i] >= 0 && en_loc[i] < 8) ? 8'h01 << en_loc[i] : 8'h00));
            wr(TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY, (en_loc[i] > 7) ? 8'h01 << (en_loc[i] - 8) : 8'h00);
            fl = (i == 1) ? 11'h7ff : 11'h7fd;
            step();
            while (m_hi || m_lo) ret();
        end
        $display("test per_source done");
        wr(TLIC_ADDR_IE, 8'h89);
        wr(TLIC_ADDR_IP, 8'h08);
        fl = 11'h044;
        step();
        fl = 11'h004;
        step();
        ret();
        step();
        fl = 11'h044;
        step();
        step();
        while (m_hi || m_lo) ret();
        $display("test nesting done");
        for (int r = 0; r < 30; r++) begin
            wr(TLIC_ADDR_IE, 8'($urandom));
            wr(TLIC_ADDR_IP, 8'($urandom));
            wr(TLIC_ADDR_IRQ_ENABLE_PRIO_SECONDARY, 8'($urandom) & 8'hf7);
            fl = 11'($urandom);
            alt = 2'($urandom_range(3, 1));
            slow = 1'($urandom);
            repeat (3) step();
            while (m_hi || m_lo) ret();
        end
        $display("test random_mix done");
        rst = 1'b1;
        fl = 11'h000;
        tick(2);
        rst = 1'b0;
        {ie, ip, ie2, m_hi, m_lo} = {8'h00, 8'h00, 8'ha0, 2'b00};
        chk_regs();
        $display("test second_reset done");
        close_out();
    end
endmodule : tb

// *** sim/tlic_core_model.sv ***
// core-side model: program counter, return stack and instruction boundary
// assumes the controller's push, load and pop pulses on the core clock
`timescale 1ns/1ps
module tlic_core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bench control
    input wire logic bnd_en,
    input wire logic slow,
    input wire logic ret_cmd,
    // controller side
    input wire logic irq_push,
    input wire logic [15:0] irq_push_pc,
    input wire logic irq_load,
    input wire logic [15:0] irq_vector,
    input wire logic irq_pop,
    output logic core_boundary,
    output logic [15:0] core_pc,
    output logic core_reti
);
    logic [15:0] stk [$];
    logic [1:0] cnt;
    // slow mode offers a boundary one cycle in four, like long instructions
    assign core_boundary = bnd_en & (~slow | (cnt == 2'h3));
    assign core_reti = ret_cmd;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stk.delete();
            core_pc <= 16'h0100;
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
            core_pc <= core_pc + 16'h0001;
            if (irq_push) stk.push_back(irq_push_pc);
            if (irq_load) core_pc <= irq_vector;
            if (irq_pop && stk.size() > 0) core_pc <= stk.pop_back();
        end
    end
endmodule : tlic_core_model
